//--- hdl/tx_status_flags.sv
/*
 * transmit-status flags of an ethernet data link controller: own-packet
 * loopback, short packet, jabber watchdog, collision retry with counter,
 * sixteen-collision policy, buffer-write timeout, interrupt mask.
 * assumes a transmitter on the same clock giving tx_start/tx_active, a
 * receiver giving own_rx_ok, and carrier/collision as raw pins.
 */
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/1ns
module tx_status_flags #(
    parameter int unsigned JABBER_LIMIT = 250000
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       tx_start,
    input  wire logic       tx_active,
    input  wire logic       own_rx_ok,
    input  wire logic       carrier_pin,
    input  wire logic       collision_pin,
    input  wire logic       bw_req,
    input  wire logic       buf_full,
    output logic            buf_wr_rdy,
    output logic            retry_pkt,
    output logic            skip_pkt,
    output logic            tx_halt,
    output logic            jab_suspend,
    output logic            irq
);
    logic [7:0]                 status_q;
    logic [7:0]                 status_d;
    logic [7:0]                 mask_q;
    logic [3:0]                 col_cnt_q;
    logic [1:0]                 col16_mode_q;
    logic [7:0]                 rdata_q;
    logic                       irq_q;
    logic                       carrier_s;
    logic                       collision_s;
    logic                       carrier_d1_q;
    logic                       collision_d1_q;
    logic                       carrier_fall;
    logic                       col_hit;
    logic                       col_last;
    logic [19:0]                jab_cnt_q;
    logic                       jab_q;
    logic                       jab_fire;
    logic                       retry_q;
    logic                       skip_q;
    logic                       halt_q;
    tx_status_pkg::bw_state_t   bw_state_q;
    logic [5:0]                 bw_cnt_q;
    logic                       bw_rdy_q;
    logic                       bw_fail;
    logic [7:0]                 clr_bits;
    logic [7:0]                 set_bits;

    // true when a register port access targets this address
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    // synchronise carrier and collision pins
    pin_sync #(.RESET_VAL(1'b0)) u_carrier_sync (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (carrier_pin),
        .level_q (carrier_s)
    );
    pin_sync #(.RESET_VAL(1'b0)) u_collision_sync (
        .clk     (clk),
        .rstn    (rstn),
        .pin     (collision_pin),
        .level_q (collision_s)
    );

    // edge history of the synchronised levels
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            carrier_d1_q   <= 1'b0;
            collision_d1_q <= 1'b0;
        end else begin
            carrier_d1_q   <= carrier_s;
            collision_d1_q <= collision_s;
        end
    end

    // event decode
    assign carrier_fall = carrier_d1_q && !carrier_s && tx_active;
    assign col_hit      = collision_s && !collision_d1_q &&
                          tx_active;
    assign col_last     = col_hit && (col_cnt_q == tx_status_pkg::COL_CNT_LAST);
    assign jab_fire     = tx_active && !jab_q &&
                          (jab_cnt_q == 20'(JABBER_LIMIT - 1));
    assign bw_fail      = (bw_state_q == tx_status_pkg::BW_WAIT) && buf_full &&
                          (bw_cnt_q == tx_status_pkg::BUS_WR_LAST);

    // host write-one-clear and hardware set terms
    always_comb begin
        clr_bits = 8'h00;
        if (reg_wr && hit(reg_addr, tx_status_pkg::ADDR_TX_STATUS)) begin
            clr_bits = reg_wdata & tx_status_pkg::W1C_BITS;
        end
        set_bits = 8'h00;
        set_bits[tx_status_pkg::BIT_OWN_RX]     = own_rx_ok;
        set_bits[tx_status_pkg::BIT_SHORT]      = carrier_fall;
        set_bits[tx_status_pkg::BIT_JABBER]     = jab_fire;
        set_bits[tx_status_pkg::BIT_COLL]       = col_hit;
        set_bits[tx_status_pkg::BIT_COL16]      = col_last;
        set_bits[tx_status_pkg::BIT_BUS_WR_ERR] = bw_fail;
    end

    // next status: packet start clears own/short, set always wins
    always_comb begin
        status_d = status_q & ~clr_bits;
        if (tx_start) begin
            status_d[tx_status_pkg::BIT_OWN_RX] = 1'b0;
            status_d[tx_status_pkg::BIT_SHORT]  = 1'b0;
        end
        status_d = (status_d | set_bits) & tx_status_pkg::STATUS_USED;
    end

    // status register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q <= tx_status_pkg::RESET_BYTE;
        end else begin
            status_q <= status_d;
        end
    end

    // mask and sixteen-collision control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask_q       <= tx_status_pkg::RESET_BYTE;
            col16_mode_q <= tx_status_pkg::MODE_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, tx_status_pkg::ADDR_TX_IRQ_MASK)) begin
                mask_q <= reg_wdata & tx_status_pkg::STATUS_USED;
            end
            if (hit(reg_addr, tx_status_pkg::ADDR_COL16_CTRL)) begin
                col16_mode_q <=
                    reg_wdata[tx_status_pkg::COL16_MODE_LSB +: 2];
            end
        end
    end

    // collision counter per packet and retry/skip/halt decisions
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            col_cnt_q <= 4'h0;
            retry_q   <= 1'b0;
            skip_q    <= 1'b0;
            halt_q    <= 1'b0;
        end else begin
            retry_q <= 1'b0;
            skip_q  <= 1'b0;
            if (tx_start) begin
                col_cnt_q <= 4'h0;
            end else if (col_hit) begin
                col_cnt_q <= col_cnt_q + 4'h1;
            end
            if (col_hit && !col_last) begin
                retry_q <= 1'b1;
            end else if (col_last) begin
                if (col16_mode_q[tx_status_pkg::COL16_HALT_BIT]) begin
                    halt_q <= 1'b1;
                end else if (col16_mode_q == tx_status_pkg::COL16_RETRY) begin
                    retry_q <= 1'b1;
                end else begin
                    skip_q <= 1'b1;
                end
            end else if (!status_q[tx_status_pkg::BIT_COL16]) begin
                halt_q <= 1'b0;
            end
        end
    end

    // jabber watchdog on continuous transmission
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            jab_cnt_q <= 20'h00000;
            jab_q     <= 1'b0;
        end else if (!tx_active) begin
            jab_cnt_q <= 20'h00000;
            jab_q     <= 1'b0;
        end else if (jab_fire) begin
            jab_q <= 1'b1;
        end else if (!jab_q) begin
            jab_cnt_q <= jab_cnt_q + 20'h00001;
        end
    end

    // host write handshake into the transmit buffer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bw_state_q <= tx_status_pkg::BW_IDLE;
            bw_cnt_q   <= 6'h00;
            bw_rdy_q   <= 1'b0;
        end else begin
            unique case (bw_state_q)
                tx_status_pkg::BW_IDLE: begin
                    bw_cnt_q <= 6'h00;
                    if (bw_req) begin
                        bw_state_q <= buf_full ? tx_status_pkg::BW_WAIT
                                               : tx_status_pkg::BW_READY;
                        bw_rdy_q   <= !buf_full;
                    end
                end
                tx_status_pkg::BW_WAIT: begin
                    if (!buf_full) begin
                        bw_state_q <= tx_status_pkg::BW_READY;
                        bw_rdy_q   <= 1'b1;
                    end else if (bw_fail) begin
                        bw_state_q <= tx_status_pkg::BW_FAIL;
                    end else begin
                        bw_cnt_q <= bw_cnt_q + 6'h01;
                    end
                end
                tx_status_pkg::BW_READY,
                tx_status_pkg::BW_FAIL: begin
                    if (!bw_req) begin
                        bw_state_q <= tx_status_pkg::BW_IDLE;
                        bw_rdy_q   <= 1'b0;
                    end
                end
            endcase
        end
    end

    // read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    tx_status_pkg::ADDR_TX_STATUS:   rdata_q <= status_q;
                    tx_status_pkg::ADDR_TX_IRQ_MASK: rdata_q <= mask_q;
                    tx_status_pkg::ADDR_COL_COUNTER:
                        rdata_q <= {col_cnt_q, 4'h0};
                    tx_status_pkg::ADDR_COL16_CTRL:
                        rdata_q <= {5'h00, col16_mode_q, 1'b0};
                    default:                         rdata_q <= 8'h00;
                endcase
            end
        end
    end

    // level interrupt from enabled, set flags
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & mask_q);
        end
    end

    assign reg_rdata   = rdata_q;
    assign irq         = irq_q;
    assign retry_pkt   = retry_q;
    assign skip_pkt    = skip_q;
    assign tx_halt     = halt_q;
    assign jab_suspend = jab_q;
    assign buf_wr_rdy  = bw_rdy_q; // flop mirrors the ready state

    // checks on the flag behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_own_clear_start: assert property (
        tx_start && !own_rx_ok |=> !status_q[tx_status_pkg::BIT_OWN_RX])
        else $error("own flag not cleared at packet start");
    a_own_set_loop: assert property (
        own_rx_ok |=> status_q[tx_status_pkg::BIT_OWN_RX])
        else $error("own flag not set on loopback");
    a_own_no_write: assert property (
        !own_rx_ok && !tx_start
        |=> $stable(status_q[tx_status_pkg::BIT_OWN_RX]))
        else $error("own flag moved without cause");
    a_short_clear_start: assert property (
        tx_start && !carrier_fall |=> !status_q[tx_status_pkg::BIT_SHORT])
        else $error("short flag not cleared at packet start");
    a_short_set_loss: assert property (
        carrier_fall |=> status_q[tx_status_pkg::BIT_SHORT])
        else $error("short flag not set on carrier loss");
    a_jabber_flag_set: assert property (
        $rose(jab_q) |-> status_q[tx_status_pkg::BIT_JABBER])
        else $error("jabber flag missing on suspend");
    a_coll_flag_set: assert property (
        col_hit |=> status_q[tx_status_pkg::BIT_COLL])
        else $error("collision flag not set");
    a_retry_after_coll: assert property (
        col_hit && !col_last |=> retry_q ##1 !retry_q)
        else $error("no single retry pulse after collision");
    a_count_step_up: assert property (
        col_hit && !tx_start |=> col_cnt_q == $past(col_cnt_q) + 4'h1)
        else $error("collision count did not step");
    a_col16_flag_set: assert property (
        col_last |=> status_q[tx_status_pkg::BIT_COL16] && !retry_q ||
                     col16_mode_q == tx_status_pkg::COL16_RETRY)
        else $error("sixteen-collision handling wrong");
    a_col16_halt_mode: assert property (
        col_last && col16_mode_q[tx_status_pkg::COL16_HALT_BIT]
        |=> halt_q && !skip_q)
        else $error("halt mode not taken");
    a_wr_timeout_err: assert property (
        bw_state_q == tx_status_pkg::BW_IDLE && bw_req && buf_full ##1
        (buf_full && bw_req) [*8]
        |-> ##[46:47] status_q[tx_status_pkg::BIT_BUS_WR_ERR] || !buf_full)
        else $error("bus write error timing wrong");
    a_w1c_jabber: assert property (
        reg_wr && reg_addr == tx_status_pkg::ADDR_TX_STATUS &&
        reg_wdata[tx_status_pkg::BIT_JABBER] && !jab_fire
        |=> !status_q[tx_status_pkg::BIT_JABBER])
        else $error("write one did not clear jabber");
    a_irq_follow_mask: assert property (
        |(status_q & mask_q) |=> irq)
        else $error("interrupt missing");
    a_irq_low_idle: assert property (
        !(|(status_q & mask_q)) |=> !irq)
        else $error("spurious interrupt");
    a_rdy_not_full: assert property (
        bw_state_q == tx_status_pkg::BW_IDLE && bw_req && !buf_full
        |=> buf_wr_rdy)
        else $error("ready missing for free buffer");

    c_col16_event:  cover property (col_last);
    c_bus_wr_fail:  cover property (bw_fail);
    c_own_loopback: cover property (own_rx_ok ##[1:20] tx_start);
    c_jabber_cut:   cover property ($rose(jab_q));
endmodule // tx_status_flags

//--- include/tx_status_pkg.sv
/*
 * constants, register map and state types for the transmit-status
 * flag block of an ethernet data link controller.
 * assumes a 25 mhz system clock and a plain 8-bit register port with 4-bit addresses.
 */
package tx_status_pkg;

    // register addresses on the local register port
    localparam logic [3:0] ADDR_TX_STATUS   = 4'h0;
    localparam logic [3:0] ADDR_TX_IRQ_MASK = 4'h2;
    localparam logic [3:0] ADDR_COL_COUNTER = 4'h4;
    localparam logic [3:0] ADDR_COL16_CTRL  = 4'hb;

    // bit positions inside transmit_status and tx_interrupt_mask
    localparam int BIT_OWN_RX     = 5;
    localparam int BIT_SHORT      = 4;
    localparam int BIT_JABBER     = 3;
    localparam int BIT_COLL       = 2;
    localparam int BIT_COL16      = 1;
    localparam int BIT_BUS_WR_ERR = 0;

    // implemented status bits and the host-clearable subset
    localparam logic [7:0] STATUS_USED = 8'h3f;
    localparam logic [7:0] W1C_BITS    = 8'h0f;
    localparam logic [7:0] RESET_BYTE  = 8'h00;

    // collision counter field and sixteen-collision control field
    localparam int         COL_CNT_LSB   = 4;
    localparam logic [3:0] COL_CNT_LAST  = 4'hf;
    localparam int         COL16_MODE_LSB = 1;
    localparam logic [1:0] COL16_SKIP    = 2'h0;
    localparam logic [1:0] COL16_RETRY   = 2'h1;
    localparam int         COL16_HALT_BIT = 1;
    localparam logic [1:0] MODE_RESET    = 2'h0;

    // host write timeout into a full transmit buffer
    localparam int CLK_PERIOD_NS  = 40;
    localparam int BUS_WR_TMO_NS  = 2150;
    localparam int BUS_WR_TMO_CYC =
        (BUS_WR_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] BUS_WR_LAST = 6'(BUS_WR_TMO_CYC - 1);

    // buffer write handshake states, gray along idle-wait-ready
    typedef enum logic [1:0] {
        BW_IDLE  = 2'h0,
        BW_WAIT  = 2'h1,
        BW_READY = 2'h3,
        BW_FAIL  = 2'h2
    } bw_state_t;

endpackage

//--- hdl/pin_sync.sv
/*
 * three-stage synchroniser for an asynchronous pin; the output only
 * moves once the second and third stages agree.
 * assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      level_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // shift chain; first stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // accept a new level once two stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            level_q <= RESET_VAL;
        end else if (s2_q == s3_q) begin
            level_q <= s3_q;
        end
    end
endmodule // pin_sync

//--- verif/link_model.sv
/*
 * partner model: transmitter, loopback receiver, line pins and host
 * buffer writes around the transmit-status flag block.
 * assumes the one 25 mhz clock of the block; no reset of its own.
 */
`timescale 1ns/1ns
module link_model (
    input  wire logic clk,
    input  wire logic buf_wr_rdy,
    output logic      tx_start,
    output logic      tx_active,
    output logic      own_rx_ok,
    output logic      carrier_pin,
    output logic      collision_pin,
    output logic      bw_req,
    output logic      buf_full
);
    // idle line at time zero
    initial begin
        tx_start      = 1'b0;
        tx_active     = 1'b0;
        own_rx_ok     = 1'b0;
        carrier_pin   = 1'b0;
        collision_pin = 1'b0;
        bw_req        = 1'b0;
        buf_full      = 1'b0;
    end

    // packet start: one-cycle pulse, carrier seen while sending
    task automatic start_pkt();
        @(posedge clk);
        tx_start    <= 1'b1;
        tx_active   <= 1'b1;
        carrier_pin <= 1'b1;
        @(posedge clk);
        tx_start <= 1'b0;
    endtask

    // carrier falls only after transmit ends, so it must be ignored
    task automatic end_pkt();
        @(posedge clk);
        tx_active <= 1'b0;
        @(posedge clk);
        carrier_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // one collision, held long enough for the pin synchroniser
    task automatic collide();
        @(posedge clk);
        collision_pin <= 1'b1;
        repeat (4) @(posedge clk);
        collision_pin <= 1'b0;
        repeat (8) @(posedge clk);
    endtask

    // carrier lost in mid-packet, then back
    task automatic lose_carrier();
        @(posedge clk);
        carrier_pin <= 1'b0;
        repeat (8) @(posedge clk);
        carrier_pin <= 1'b1;
        repeat (8) @(posedge clk);
    endtask

    // own packet seen back on the receive side
    task automatic own_echo();
        @(posedge clk);
        own_rx_ok <= 1'b1;
        @(posedge clk);
        own_rx_ok <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    // host buffer write request and buffer state, held by caller
    task automatic bw_set(input logic req, input logic full);
        @(posedge clk);
        bw_req   <= req;
        buf_full <= full;
    endtask
endmodule // link_model

//--- verif/tb_top.sv
/*
 * self-checking bench of the transmit-status flag block.
 * assumes link_model for the line side; registers via plain port.
 */
`timescale 1ns/1ns
module tb_top;
    localparam int JAB = 400;
    logic       clk;
    logic       rstn;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_rdata;
    logic       tx_start, tx_active, own_rx_ok, carrier_pin;
    logic       collision_pin, bw_req, buf_full, buf_wr_rdy;
    logic       retry_pkt, skip_pkt, tx_halt, jab_suspend, irq;
    int         n_fail, checks_done, cyc, n_retry, n_skip;
    logic [7:0] d;

    tx_status_flags #(.JABBER_LIMIT(JAB)) u_tx_status_flags (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_start(tx_start),
        .tx_active(tx_active), .own_rx_ok(own_rx_ok),
        .carrier_pin(carrier_pin), .collision_pin(collision_pin),
        .bw_req(bw_req), .buf_full(buf_full), .buf_wr_rdy(buf_wr_rdy),
        .retry_pkt(retry_pkt), .skip_pkt(skip_pkt), .tx_halt(tx_halt),
        .jab_suspend(jab_suspend), .irq(irq));
    link_model u_link_model (
        .clk(clk), .buf_wr_rdy(buf_wr_rdy), .tx_start(tx_start),
        .tx_active(tx_active), .own_rx_ok(own_rx_ok),
        .carrier_pin(carrier_pin), .collision_pin(collision_pin),
        .bw_req(bw_req), .buf_full(buf_full));

    // clock, pulse counters and hang limit
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (retry_pkt === 1'b1) n_retry <= n_retry + 1;
        if (skip_pkt === 1'b1) n_skip <= n_skip + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = reg_rdata;
    endtask
    task automatic chk_irq(input logic exp);
        repeat (3) @(negedge clk);
        check({7'h0, irq}, {7'h0, exp});
    endtask

    task automatic t_regs();
        logic [3:0] a[5] = '{4'h0, 4'h2, 4'h4, 4'hb, 4'h7};
        foreach (a[i]) begin
            rd(a[i], d);
            check(d, 8'h00);
        end
        wr(tx_status_pkg::ADDR_COL_COUNTER, 8'hff);
        rd(tx_status_pkg::ADDR_COL_COUNTER, d);
        check(d, 8'h00);
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'hff);
        rd(tx_status_pkg::ADDR_TX_IRQ_MASK, d);
        check(d, 8'h3f);
        wr(tx_status_pkg::ADDR_COL16_CTRL, 8'hff);
        rd(tx_status_pkg::ADDR_COL16_CTRL, d);
        check(d, 8'h06);
        wr(4'h7, 8'hff);
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'h00);
        wr(tx_status_pkg::ADDR_COL16_CTRL, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_collision();
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'h04);
        u_link_model.start_pkt();
        n_retry = 0;
        u_link_model.collide();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h04);
        rd(tx_status_pkg::ADDR_COL_COUNTER, d);
        check(d, 8'h10);
        check(8'(n_retry), 8'h01);
        check({7'h0, irq}, 8'h01);
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'h3b);
        chk_irq(1'b0);
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'h04);
        wr(tx_status_pkg::ADDR_TX_STATUS, 8'hfb);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h04);
        check({7'h0, irq}, 8'h01);
        wr(tx_status_pkg::ADDR_TX_STATUS, 8'h04);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        chk_irq(1'b0);
        u_link_model.end_pkt();
        u_link_model.collide();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        rd(tx_status_pkg::ADDR_COL_COUNTER, d);
        check(d, 8'h10);
        wr(tx_status_pkg::ADDR_TX_IRQ_MASK, 8'h00);
        $display("test collision done");
    endtask

    // every sixteen-collision mode, counter wraps on the sixteenth
    task automatic t_sixteen();
        for (int m = 0; m < 4; m++) begin
            wr(tx_status_pkg::ADDR_COL16_CTRL, 8'(m << 1));
            u_link_model.start_pkt();
            n_retry = 0;
            n_skip  = 0;
            repeat (16) u_link_model.collide();
            rd(tx_status_pkg::ADDR_TX_STATUS, d);
            check(d, 8'h06);
            rd(tx_status_pkg::ADDR_COL_COUNTER, d);
            check(d, 8'h00);
            check(8'(n_retry), (m == 1) ? 8'h10 : 8'h0f);
            check(8'(n_skip), (m == 0) ? 8'h01 : 8'h00);
            check({7'h0, tx_halt}, 8'(m >> 1));
            wr(tx_status_pkg::ADDR_TX_STATUS, 8'h06);
            u_link_model.end_pkt();
            check({7'h0, tx_halt}, 8'h00);
        end
        wr(tx_status_pkg::ADDR_COL16_CTRL, 8'h00);
        $display("test sixteen done");
    endtask

    task automatic t_short_own();
        u_link_model.start_pkt();
        u_link_model.lose_carrier();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h10);
        u_link_model.own_echo();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h30);
        wr(tx_status_pkg::ADDR_TX_STATUS, 8'h30);
        u_link_model.end_pkt();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h30);
        u_link_model.start_pkt();
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        u_link_model.end_pkt();
        $display("test short and own done");
    endtask

    task automatic t_jabber();
        int n;
        n = 0;
        u_link_model.start_pkt();
        while (jab_suspend !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        check({7'h0, (n > JAB - 4 && n < JAB + 4)}, 8'h01);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h08);
        u_link_model.end_pkt();
        check({7'h0, jab_suspend}, 8'h00);
        wr(tx_status_pkg::ADDR_TX_STATUS, 8'h08);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        $display("test jabber done");
    endtask

    task automatic t_bufwr();
        int n;
        n = 0;
        u_link_model.bw_set(1'b1, 1'b0);
        while (buf_wr_rdy !== 1'b1 && n < 10) begin
            @(negedge clk);
            n++;
        end
        check(8'(n), 8'h02);
        u_link_model.bw_set(1'b0, 1'b1);
        u_link_model.bw_set(1'b1, 1'b1);
        repeat (40) @(posedge clk);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        repeat (20) @(posedge clk);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h01);
        check({7'h0, buf_wr_rdy}, 8'h00);
        u_link_model.bw_set(1'b0, 1'b0);
        wr(tx_status_pkg::ADDR_TX_STATUS, 8'h01);
        rd(tx_status_pkg::ADDR_TX_STATUS, d);
        check(d, 8'h00);
        $display("test buffer write done");
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // reset for four cycles, then the scenarios
    initial begin
        rstn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        n_fail = 0;
        checks_done = 0;
        cyc = 0;
        n_retry = 0;
        n_skip = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_regs();
        t_collision();
        t_sixteen();
        t_short_own();
        t_jabber();
        t_bufwr();
        report_and_stop();
    end
endmodule // tb_top
